// >>> design/cfd_regs.svh
// Constants for the channel fault diagnosis block
// Summary of operation
// RQ1: Each channel holds a two-bit code: 00 short to ground, 01 open load, 10 overcurrent, 11 no fault.
// RQ2: Codes have no priority; any newly detected condition overwrites the held code.
// RQ3: Overcurrent or overtemperature switches the channel off and records code 10.
// RQ4: Each off-state diagnosis is qualified by a filter delay of at most 220 us before it is stored; blind time gives channels 7 to 10 up to 5 ms.
// RQ5: A change between short to ground and open load while pending keeps the timer and stores the latest.
// RQ6: The host avoids off periods shorter than the 220 us maximum filter delay.
// RQ7: Blind-time bits lengthen the filter of channels 7 to 10 to typically 2.5 ms or 5 ms.
// RQ8: The host pairs channels 7 with 8 and 9 with 10 for anti-parallel loads.
// RQ9: After reading open load the host holds the channel off for the filter delay and rereads.
// RQ10: After reading overcurrent the host clears the off-diagnosis enable and then issues a clear.
// RQ11: During confirmation the host switches the channel on, rereads, then sets the enable again.
// RQ12: A clear command for a channel returns its code to no fault.
// RQ13: A channel switched off by overcurrent stays off until cleared or overridden by a new code.
// RQ14: Off-state diagnoses are evaluated only while the channel's off-diagnosis enable is set.
`ifndef CFD_REGS_SVH
`define CFD_REGS_SVH
`define CFD_CLK_HZ 10000000
`define CFD_TD_STD_US 220
`define CFD_TD_MID_US 2500
`define CFD_TD_LONG_US 5000
`define CFD_CYC(us) ((us) * (`CFD_CLK_HZ / 1000000))
`define CFD_TD_STD_CYC `CFD_CYC(`CFD_TD_STD_US)
`define CFD_TD_MID_CYC `CFD_CYC(`CFD_TD_MID_US)
`define CFD_TD_LONG_CYC `CFD_CYC(`CFD_TD_LONG_US)
`define CFD_NUM_CH 10
`define CFD_FIRST_EXT_CH 6
`define CFD_DIAG_ENABLE_RST 1'b1
`endif

// >>> design/cfd_pkg.sv
// Types for the channel fault diagnosis block
package cfd_pkg;
  typedef enum logic [1:0] {
    CFD_SCG = 2'h0,
    CFD_OL = 2'h1,
    CFD_OCT = 2'h2,
    CFD_OK = 2'h3
  } cfd_code_type;
  // Filter state, Gray order idle -> pending -> store
  typedef enum logic [1:0] {
    CFD_IDLE = 2'h0,
    CFD_PEND = 2'h1,
    CFD_STORE = 2'h3
  } cfd_state_type;
  // Synchronised detector levels of one channel
  typedef struct packed {
    logic short_to_ground;
    logic open_load;
    logic overcurrent_overtemp;
  } cfd_det_type;
  typedef enum logic [1:0] {
    CFD_BT_STD = 2'h0,
    CFD_BT_MID = 2'h2,
    CFD_BT_LONG = 2'h3
  } cfd_bt_type;
endpackage : cfd_pkg

// >>> design/cfd_channel.sv
// One channel: delay filter, code store and overcurrent latch
`include "cfd_regs.svh"
module cfd_channel #(
  parameter int CNT_W = 16
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, low
  input wire logic [CNT_W-1:0] delay_cyc, // Filter length in cycles
  input cfd_pkg::cfd_det_type det, // Synchronised detector levels
  input wire logic ctrl_on, // Requested channel state
  input wire logic off_diag_enable, // Off-state diagnosis enable
  input wire logic diag_clear_cmd, // One-cycle clear pulse
  output cfd_pkg::cfd_code_type channel_diag_code, // Stored code
  output logic out_on // Power stage drive
);
  cfd_pkg::cfd_state_type state_reg, state_next;
  cfd_pkg::cfd_code_type code_reg, code_next, pend_reg, pend_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic latch_reg, latch_next;
  logic out_reg, out_next;
  logic off_cond;

  // Counter must hold more than one bit
  if (CNT_W < 2) begin : g_bad_width
    $error("cfd_channel: CNT_W too small");
  end

  // Off-state faults seen only while off and enabled
  assign off_cond = !out_reg && off_diag_enable && (det.short_to_ground || det.open_load); // [RQ14]

  // Next state of filter, code and latch
  always_comb begin
    state_next = state_reg;
    code_next = code_reg;
    pend_next = pend_reg;
    cnt_next = cnt_reg;
    latch_next = latch_reg;
    case (state_reg)
      cfd_pkg::CFD_IDLE: begin
        if (off_cond) begin
          state_next = cfd_pkg::CFD_PEND; // [RQ4]
          cnt_next = delay_cyc;
          pend_next = det.short_to_ground ? cfd_pkg::CFD_SCG : cfd_pkg::CFD_OL;
        end
      end
      cfd_pkg::CFD_PEND: begin
        if (!off_cond) begin
          state_next = cfd_pkg::CFD_IDLE; // Condition vanished, nothing stored
        end else begin
          // Flip between the two keeps the running timer
          pend_next = det.short_to_ground ? cfd_pkg::CFD_SCG : cfd_pkg::CFD_OL; // [RQ5]
          if (cnt_reg <= CNT_W'(1)) begin
            state_next = cfd_pkg::CFD_STORE;
          end else begin
            cnt_next = cnt_reg - CNT_W'(1);
          end
        end
      end
      cfd_pkg::CFD_STORE: begin
        code_next = pend_reg; // [RQ2] [RQ4]
        latch_next = 1'b0; // New code overrides the trip [RQ13]
        if (!off_cond) state_next = cfd_pkg::CFD_IDLE;
      end
      default: state_next = cfd_pkg::CFD_IDLE;
    endcase
    // Clear after the filter store but before overcurrent, so a simultaneous overcurrent still lands
    if (diag_clear_cmd) begin
      code_next = cfd_pkg::CFD_OK; // [RQ12]
      latch_next = 1'b0; // [RQ13]
    end
    // Overcurrent acts at once, no filter; it trips the stage
    if (out_reg && det.overcurrent_overtemp) begin
      code_next = cfd_pkg::CFD_OCT; // [RQ3] [RQ2]
      latch_next = 1'b1; // [RQ3] [RQ13]
    end
    out_next = ctrl_on && !latch_next; // [RQ13]
  end

  // Register the channel state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= cfd_pkg::CFD_IDLE;
      code_reg <= cfd_pkg::CFD_OK;
      pend_reg <= cfd_pkg::CFD_OK;
      cnt_reg <= '0;
      latch_reg <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      code_reg <= code_next;
      pend_reg <= pend_next;
      cnt_reg <= cnt_next;
      latch_reg <= latch_next;
      out_reg <= out_next;
    end
  end

  assign channel_diag_code = code_reg; // [RQ1]
  assign out_on = out_reg;
endmodule : cfd_channel

// >>> design/cfd_diag.sv
// Ten-channel fault diagnosis top
`include "cfd_regs.svh"
module cfd_diag #(
  parameter int NUM_CH = `CFD_NUM_CH,
  parameter int TD_STD_CYC = `CFD_TD_STD_CYC,
  parameter int TD_MID_CYC = `CFD_TD_MID_CYC,
  parameter int TD_LONG_CYC = `CFD_TD_LONG_CYC
) (
  input wire logic CLK, // 10 MHz clock
  input wire logic RST_N, // Synchronous reset, low
  input wire logic [NUM_CH-1:0] CTRL_ON, // Channel on requests
  input wire logic [NUM_CH-1:0] DET_SHORT_TO_GROUND, // Raw short detector
  input wire logic [NUM_CH-1:0] DET_OPEN_LOAD, // Raw open-load detector
  input wire logic [NUM_CH-1:0] DET_OVERCURRENT_OVERTEMP, // Raw overload detector
  input wire logic [NUM_CH-1:0] OFF_DIAG_ENABLE, // Off-state diagnosis enables
  input wire logic [NUM_CH-1:0] DIAG_CLEAR_CMD, // Clear pulses, one per channel
  input wire logic [1:0] DIAG_BLIND_TIME_SEL, // Filter length, channels 7 to 10
  output logic [2*NUM_CH-1:0] CHANNEL_DIAG_CODE, // Two bits per channel
  output logic [NUM_CH-1:0] OUT_ON // Power stage drives
);
  localparam int CNT_W = $clog2(TD_LONG_CYC + 1);
  logic [NUM_CH-1:0] sg_s1, sg_s2, ol_s1, ol_s2, oc_s1, oc_s2;
  logic [CNT_W-1:0] dly_std, dly_ext;

  // Refuse sizes the channel split and counters cannot serve
  if (NUM_CH < `CFD_FIRST_EXT_CH + 1) begin : g_bad_count
    $error("cfd_diag: NUM_CH too small");
  end
  if (TD_STD_CYC < 1 || TD_MID_CYC < TD_STD_CYC || TD_LONG_CYC < TD_MID_CYC) begin : g_bad_len
    $error("cfd_diag: bad filter lengths");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Detectors are analog, asynchronous: two flops each
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sg_s1 <= '0;
      sg_s2 <= '0;
      ol_s1 <= '0;
      ol_s2 <= '0;
      oc_s1 <= '0;
      oc_s2 <= '0;
    end else begin
      sg_s1 <= DET_SHORT_TO_GROUND;
      sg_s2 <= sg_s1;
      ol_s1 <= DET_OPEN_LOAD;
      ol_s2 <= ol_s1;
      oc_s1 <= DET_OVERCURRENT_OVERTEMP;
      oc_s2 <= oc_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Blind-time decode; upper bit selects an extended length, lower bit picks 5 ms over 2.5 ms
  always_comb begin
    dly_std = CNT_W'(TD_STD_CYC); // [RQ4]
    case (DIAG_BLIND_TIME_SEL)
      cfd_pkg::CFD_BT_MID: dly_ext = CNT_W'(TD_MID_CYC); // [RQ7]
      cfd_pkg::CFD_BT_LONG: dly_ext = CNT_W'(TD_LONG_CYC); // [RQ7]
      default: dly_ext = CNT_W'(TD_STD_CYC);
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // One filter per channel; channels 7 to 10 take the extended length
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    cfd_channel #(.CNT_W(CNT_W)) u_ch (
      .clk(CLK),
      .rst_n(RST_N),
      .delay_cyc((i >= `CFD_FIRST_EXT_CH) ? dly_ext : dly_std), // [RQ7]
      .det('{short_to_ground: sg_s2[i], open_load: ol_s2[i],
             overcurrent_overtemp: oc_s2[i]}),
      .ctrl_on(CTRL_ON[i]),
      .off_diag_enable(OFF_DIAG_ENABLE[i]),
      .diag_clear_cmd(DIAG_CLEAR_CMD[i]),
      .channel_diag_code(CHANNEL_DIAG_CODE[2*i +: 2]),
      .out_on(OUT_ON[i])
    );
  end
endmodule : cfd_diag

// >>> bench/cfd_diag_asserts.sv
// Port checks for the diagnosis top
module cfd_diag_asserts #(parameter int NUM_CH = 10) (
  input wire logic CLK, // Clock
  input wire logic RST_N, // Reset
  input wire logic [NUM_CH-1:0] CTRL_ON, // Requests
  input wire logic [NUM_CH-1:0] DET_SHORT_TO_GROUND, // Short
  input wire logic [NUM_CH-1:0] DET_OPEN_LOAD, // Open
  input wire logic [NUM_CH-1:0] DET_OVERCURRENT_OVERTEMP, // Overload
  input wire logic [NUM_CH-1:0] OFF_DIAG_ENABLE, // Enables
  input wire logic [NUM_CH-1:0] DIAG_CLEAR_CMD, // Clears
  input wire logic [1:0] DIAG_BLIND_TIME_SEL, // Length
  input wire logic [2*NUM_CH-1:0] CHANNEL_DIAG_CODE, // Codes
  input wire logic [NUM_CH-1:0] OUT_ON // Drives
);
  // Channel 0 sees the standard filter, the last one the extended
  wire logic [1:0] c0 = CHANNEL_DIAG_CODE[1:0];
  wire logic [1:0] cl = CHANNEL_DIAG_CODE[2*NUM_CH-1-:2];
  wire logic off0 = !OUT_ON[0] && OFF_DIAG_ENABLE[0];
  wire logic offl = !OUT_ON[NUM_CH-1] && OFF_DIAG_ENABLE[NUM_CH-1];
  wire logic ol0 = off0 && DET_OPEN_LOAD[0] && !DET_SHORT_TO_GROUND[0] && !DIAG_CLEAR_CMD[0];
  wire logic det0 = DET_SHORT_TO_GROUND[0] || DET_OPEN_LOAD[0];
  wire logic oc0 = CTRL_ON[0] && DET_OVERCURRENT_OVERTEMP[0];
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_reset_idle: assert property (disable iff (1'b0) !RST_N |=> &CHANNEL_DIAG_CODE && !OUT_ON)
    else $error("not idle after reset");
  a_trip_off: assert property ($rose(DET_OVERCURRENT_OVERTEMP[0]) && OUT_ON[0] && CTRL_ON[0]
    ##1 oc0 [*2] |-> ##[0:2] (c0 == 2'h2 && !OUT_ON[0]))
    else $error("overload did not trip");
  a_trip_latch: assert property (c0 == 2'h2 |-> !OUT_ON[0])
    else $error("tripped channel driven");
  a_clear_ok: assert property (DIAG_CLEAR_CMD[0] && !OFF_DIAG_ENABLE[0] && !$past(OFF_DIAG_ENABLE[0])
    && !$past(DET_OVERCURRENT_OVERTEMP[0], 2) |=> c0 == 2'h3)
    else $error("clear ignored");
  a_off_enabled: assert property (!c0[1] && c0 != $past(c0) |-> $past(off0))
    else $error("off code while not allowed");
  // Pin seen 12 samples and off state 10 samples before a stored code, for 8 filter cycles
  a_filter_min: assert property (!c0[1] && c0 != $past(c0)
    |-> $past(det0, 12) && $past(off0, 10))
    else $error("off code too early");
  a_filter_max: assert property (ol0 [*8] |-> ##[0:8] (c0 == 2'h1 || !ol0))
    else $error("open load not stored");
  a_ext_length: assert property (!cl[1] && cl != $past(cl) && DIAG_BLIND_TIME_SEL == 2'h3
    && $past(DIAG_BLIND_TIME_SEL, 40) == 2'h3 |-> $past(offl, 40))
    else $error("long filter too short");
  c_open: cover property (c0 == 2'h1);
  c_trip: cover property (c0 == 2'h2);
  c_short: cover property (cl == 2'h0);
endmodule : cfd_diag_asserts
bind cfd_diag cfd_diag_asserts #(.NUM_CH(NUM_CH)) u_chk (.CLK(CLK), .RST_N(RST_N),
  .CTRL_ON(CTRL_ON), .DET_SHORT_TO_GROUND(DET_SHORT_TO_GROUND), .DET_OPEN_LOAD(DET_OPEN_LOAD),
  .DET_OVERCURRENT_OVERTEMP(DET_OVERCURRENT_OVERTEMP), .OFF_DIAG_ENABLE(OFF_DIAG_ENABLE),
  .DIAG_CLEAR_CMD(DIAG_CLEAR_CMD), .DIAG_BLIND_TIME_SEL(DIAG_BLIND_TIME_SEL),
  .CHANNEL_DIAG_CODE(CHANNEL_DIAG_CODE), .OUT_ON(OUT_ON));

// >>> bench/cfd_host.sv
// Host model: requests, enables and clear pulses
module cfd_host (
  input wire logic clk, // Clock
  output logic [9:0] ctrl_on, // Requests
  output logic [9:0] off_diag_enable, // Enables
  output logic [9:0] diag_clear_cmd // Clears
);
  initial begin
    ctrl_on = '0;
    off_diag_enable = '1;
    diag_clear_cmd = '0;
  end
  // Changes land just after an edge, never on it
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic clear(input int ch);
    diag_clear_cmd[ch] = 1'b1;
    step(1);
    diag_clear_cmd[ch] = 1'b0;
  endtask : clear
  // Off for n cycles; at the filter length the code is not yet stored
  task automatic hold_off(input int ch, input int n);
    ctrl_on[ch] = 1'b0;
    step(n);
  endtask : hold_off
  // Enable off before the clear, else an off fault may land at once
  task automatic retry(input int ch);
    off_diag_enable[ch] = 1'b0;
    step(1);
    clear(ch);
    ctrl_on[ch] = 1'b1;
    step(3);
  endtask : retry
  // Anti-parallel loads sit on neighbour pairs so their disturbance stays local
  task automatic antiphase(input int first, input logic lvl);
    ctrl_on[first] = lvl;
    ctrl_on[first + 1] = !lvl;
    step(2);
  endtask : antiphase
endmodule : cfd_host

// >>> bench/cfd_diag_tb_top.sv
// Bench for the diagnosis block
module cfd_diag_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n;
  logic [9:0] sc, ol, oc, on, ct, en, cl;
  logic [1:0] sel;
  logic [19:0] cd;
  int mismatches = 0;
  int checks = 0;
  always #50 clk = ~clk;
  cfd_host host (.clk(clk), .ctrl_on(ct), .off_diag_enable(en), .diag_clear_cmd(cl));
  cfd_diag #(.TD_STD_CYC(8), .TD_MID_CYC(20), .TD_LONG_CYC(40)) dut (.CLK(clk), .RST_N(rst_n),
    .CTRL_ON(ct), .DET_SHORT_TO_GROUND(sc), .DET_OPEN_LOAD(ol), .DET_OVERCURRENT_OVERTEMP(oc),
    .OFF_DIAG_ENABLE(en), .DIAG_CLEAR_CMD(cl), .DIAG_BLIND_TIME_SEL(sel),
    .CHANNEL_DIAG_CODE(cd), .OUT_ON(on));
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  // Filter cycles per channel and select, as instantiated
  function automatic int filt(input int ch, input logic [1:0] s);
    return (ch < 6 || !s[1]) ? 8 : (s[0] ? 40 : 20);
  endfunction : filt
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  initial begin
    int ch;
    logic s;
    rst_n = 1'b0;
    {sc, ol, oc} = '0;
    sel = 2'h0;
    void'($urandom(32'h2c4f04a7));
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    check("reset code", cd[19:18], 2'h3);
    for (int i = 0; i < 8; i++) begin
      // Last pass pins the final channel so the long filter is always seen there
      ch = (i < 4) ? $urandom_range(5, 0) : ((i == 7) ? 9 : $urandom_range(9, 6));
      sel = 2'(i % 4);
      s = 1'($urandom_range(1, 0));
      sc[ch] = s;
      ol[ch] = !s;
      host.hold_off(ch, filt(ch, sel));
      check("early code", cd[2*ch+:2], 2'h3);
      host.step(6);
      check("off code", cd[2*ch+:2], {1'b0, !s});
      {sc[ch], ol[ch]} = 2'h0;
      host.step(3);
      host.clear(ch);
      check("cleared", cd[2*ch+:2], 2'h3);
    end
    $display("test filter done");
    ol[0] = 1'b1;
    host.step(4);
    {sc[0], ol[0]} = 2'h2;
    host.step(9);
    check("latest", cd[1:0], 2'h0);
    sc[0] = 1'b0;
    host.step(3);
    ol[0] = 1'b1;
    host.step(14);
    check("override", cd[1:0], 2'h1);
    ol[0] = 1'b0;
    host.off_diag_enable[0] = 1'b0;
    host.step(3);
    host.clear(0);
    ol[0] = 1'b1;
    host.step(20);
    check("disabled", cd[1:0], 2'h3);
    ol[0] = 1'b0;
    host.off_diag_enable[0] = 1'b1;
    $display("test override done");
    // Overload on a channel that is off must be ignored
    oc[1] = 1'b1;
    host.step(5);
    check("off overload", cd[3:2], 2'h3);
    oc[1] = 1'b0;
    host.step(3);
    for (int i = 0; i < 2; i++) begin
      ch = (i == 0) ? 0 : $urandom_range(9, 1);
      host.ctrl_on[ch] = 1'b1;
      host.step(3);
      oc[ch] = 1'b1;
      host.step(6);
      check("trip", cd[2*ch+:2], 2'h2);
      oc[ch] = 1'b0;
      host.step(4);
      check("latched", {1'b0, on[ch]}, 2'h0);
      host.retry(ch);
      check("retry code", cd[2*ch+:2], 2'h3);
      check("retry drive", {1'b0, on[ch]}, 2'h1);
      host.off_diag_enable[ch] = 1'b1;
      host.ctrl_on[ch] = 1'b0;
      host.step(2);
    end
    $display("test trip done");
    // A filtered open load overrides a trip and releases the latch
    host.ctrl_on[0] = 1'b1;
    host.step(3);
    oc[0] = 1'b1;
    host.step(5);
    {oc[0], ol[0]} = 2'h1;
    host.step(14);
    check("trip override", cd[1:0], 2'h1);
    check("released", {1'b0, on[0]}, 2'h1);
    {ol[0], host.ctrl_on[0]} = 2'h0;
    host.step(3);
    host.clear(0);
    check("released clear", cd[1:0], 2'h3);
    $display("test release done");
    // Neighbour pairs driven in anti-phase follow their requests
    for (int i = 0; i < 4; i++) begin
      ch = (i < 2) ? 6 : 8;
      s = 1'($urandom_range(1, 0));
      host.antiphase(ch, s);
      check("pair drive", {on[ch + 1], on[ch]}, {!s, s});
    end
    host.ctrl_on[9:6] = 4'h0;
    host.step(2);
    $display("test pair done");
    conclude();
  end
  // Runs take under two thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule : cfd_diag_tb_top
